// file: stepper_io_consts.svh
// Constants for the stepper driver discrete I/O control block
`ifndef STEPPER_IO_CONSTS_SVH
`define STEPPER_IO_CONSTS_SVH

// Input function codes for the general-purpose command inputs
`define FN_IN_NONE       4'h0
`define FN_IN_HOME       4'h1
`define FN_IN_HALT       4'h2
`define FN_IN_FREE       4'h3
`define FN_IN_CLEAR      4'h4
`define FN_IN_FWD_JOG    4'h5
`define FN_IN_REV_JOG    4'h6

// Output function codes for the general-purpose status outputs
`define FN_OUT_HOME_DONE 4'h0
`define FN_OUT_POS_DONE  4'h1
`define FN_OUT_ACCEPT    4'h2
`define FN_OUT_READY     4'h3
`define FN_OUT_MOTION    4'h4
`define FN_OUT_FAULT_NC  4'h5
`define FN_OUT_OFF       4'hF

// Power-on input assignment, inputs 0..5 (pins IN4..IN9)
// Input 0 home, 1 de-energize, 2 halt, 3 fault clear, 4 forward jog, 5 reverse jog
`define IN_MAP_DEFAULT   24'h654231
// Power-on output assignment, outputs 0..5 (OUT0..OUT5)
`define OUT_MAP_DEFAULT  24'h543210

// Cycles from release of reset until step pulses are accepted
`define PREP_TIME_US     100
`define CLK_MHZ          25
`define PREP_CYCLES      (`PREP_TIME_US * `CLK_MHZ)
// Cycles between jog steps and home-return steps
`define JOG_PERIOD       16'h0FA0
// Idle cycles after each quadrature phase move before the next one
`define QUAD_DWELL       4'h4

`endif

// file: stepper_io_pkg.sv
// Types for the stepper driver discrete I/O control block
package stepper_io_pkg;
	typedef enum logic [2:0] {
		st_prep    = 3'b000,
		st_idle    = 3'b001,
		st_pulse   = 3'b010,
		st_jog     = 3'b011,
		st_home    = 3'b100,
		st_fault   = 3'b101,
		st_free    = 3'b110
	} drive_state_t;
	typedef logic [3:0] fn_code_t;
	typedef logic signed [31:0] position_t;
endpackage

// file: quad_echo.sv
// Quadrature echo of shaft steps on phase A and phase B
`timescale 1ns/1ps
`include "stepper_io_consts.svh"
module quad_echo #(
	parameter int PENDING_W = 8
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic step_event,
	input  wire logic step_ccw,
	output logic      phase_a,
	output logic      phase_b
);
	logic signed [PENDING_W-1:0] pending;
	logic [1:0]                  phase;
	logic [3:0]                  dwell;
	logic                        move_now;
	logic                        dir_ccw;

	if (PENDING_W < 2) begin : g_bad_width
		$error("quad_echo: PENDING_W too small");
	end

	assign move_now = (pending != '0) && (dwell == 4'h0);
	assign dir_ccw  = pending[PENDING_W-1];

	// Backlog of steps not yet echoed; the echo is slower than the step rate
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pending <= '0;
		end else begin
			pending <= PENDING_W'(pending
				+ (step_event ? (step_ccw ? -1 : 1) : 0)
				- (move_now ? (dir_ccw ? -1 : 1) : 0));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dwell <= 4'h0;
		end else if (move_now) begin
			dwell <= `QUAD_DWELL;
		end else if (dwell != 4'h0) begin
			dwell <= dwell - 4'h1;
		end
	end

	// Gray sequence: A leads B clockwise, B leads A counter-clockwise
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase <= 2'h0;
		end else if (move_now) begin
			phase <= dir_ccw ? phase - 2'h1 : phase + 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase_a <= 1'b0;
			phase_b <= 1'b0;
		end else begin
			phase_a <= phase[1] ^ phase[0];
			phase_b <= phase[1];
		end
	end
endmodule

// file: stepper_driver_io_control.sv
// Discrete I/O control logic of a pulse-input stepper motor driver
// Function
// - Two-pulse format: each clockwise input pulse not rising with a counter-clockwise one moves one step clockwise.
// - Two-pulse format: each counter-clockwise input pulse not rising with a clockwise one moves one step back.
// - One-pulse format: first pair is step pulse, second pair is turn sense.
// - Format chosen by configuration switch; one-pulse is the default.
// - Home-return command drives motor to the stored home position.
// - After preparation, while de-energize command is on, windings carry no excitation.
// - Home-done set when home is set or a home return completes.
// - Step-accepting output set only once preparation has finished.
// - Motion-active output high for the whole time the motor moves.
// - Positioning-done output set when a commanded operation completes.
// - Ready output high only while operation commands can be accepted.
// - Fault output is normally closed: on when healthy, off on fault.
// - Either safety cutoff input off removes drive power, bypassing logic.
// - Cutoff monitor on only when both safety cutoff inputs are off.
// - General inputs and outputs reassignable by parameter, listed defaults.
// - Step inputs, commons and ground keep fixed, unassignable functions.
`timescale 1ns/1ps
`include "stepper_io_consts.svh"
module stepper_driver_io_control #(
	parameter int          N_IN        = 6,
	parameter int          N_OUT       = 6,
	parameter int          PREP_CYCLES = `PREP_CYCLES,
	parameter logic [23:0] IN_MAP      = `IN_MAP_DEFAULT,
	parameter logic [23:0] OUT_MAP     = `OUT_MAP_DEFAULT
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              one_pulse_mode_sw,
	input  wire logic              clockwise_step_in,
	input  wire logic              counter_clockwise_step_in,
	input  wire logic [N_IN-1:0]   gp_in,
	input  wire logic              safety_cutoff_one_in,
	input  wire logic              safety_cutoff_two_in,
	input  wire logic              home_preset_sw,
	input  wire logic              fault_detect_in,
	output logic [N_OUT-1:0]       gp_out,
	output logic                   drive_enable_out,
	output logic                   step_out,
	output logic                   step_ccw_out,
	output logic                   cutoff_monitor_out,
	output logic                   quad_phase_a_out,
	output logic                   quad_phase_b_out
);
	import stepper_io_pkg::*;

	drive_state_t            state;
	stepper_io_pkg::position_t position;
	stepper_io_pkg::position_t home_position;
	logic [15:0]             prep_count;
	logic [15:0]             tick;
	logic                    prev_a;
	logic                    prev_b;
	logic                    pulse_edge;
	logic                    pulse_ccw;
	logic                    home_return_cmd;
	logic                    halt_cmd;
	logic                    free_cmd;
	logic                    fault_clear_cmd;
	logic                    forward_jog_cmd;
	logic                    reverse_jog_cmd;
	logic                    prev_home_cmd;
	logic                    fault_latched;
	logic                    home_done;
	logic                    pos_done;
	logic                    step_input_accepting_out;
	logic                    moving;
	logic                    next_step;
	logic                    next_ccw;
	logic                    power_ok;
	logic [5:0]              status_vec;
	logic [N_IN*7-1:0]       fn_hits;

	if (N_IN != 6 || N_OUT != 6) begin : g_bad_io
		$error("Six general inputs and outputs are required");
	end
	if (PREP_CYCLES < 1 || PREP_CYCLES > 65535) begin : g_bad_prep
		$error("PREP_CYCLES out of range");
	end

	// Step pins are wired straight to the decoder; no map touches them
	assign power_ok = safety_cutoff_one_in && safety_cutoff_two_in;

	// Per-input function decode through the assignment map
	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++) begin : g_in_map
			logic [3:0] code;
			assign code = IN_MAP[gi*4 +: 4];
			assign fn_hits[gi*7 +: 7] = gp_in[gi] ? (7'h01 << code) : 7'h00;
		end
	endgenerate

	always_comb begin
		logic [6:0] any;
		any = 7'h00;
		for (int i = 0; i < N_IN; i++) begin
			any = any | fn_hits[i*7 +: 7];
		end
		home_return_cmd = any[1];
		halt_cmd        = any[2];
		free_cmd        = any[3];
		fault_clear_cmd = any[4];
		forward_jog_cmd = any[5];
		reverse_jog_cmd = any[6];
	end

	// Step pulse decode on rising edges of the step pins
	always_comb begin
		if (one_pulse_mode_sw) begin
			pulse_edge = clockwise_step_in && !prev_a;
			pulse_ccw  = counter_clockwise_step_in;
		end else begin
			// Both rising together cancel: net motion is zero
			pulse_edge = (clockwise_step_in && !prev_a) ^ (counter_clockwise_step_in && !prev_b);
			pulse_ccw  = counter_clockwise_step_in && !prev_b;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else begin
			prev_a <= clockwise_step_in;
			prev_b <= counter_clockwise_step_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prev_home_cmd <= 1'b0;
		end else begin
			prev_home_cmd <= home_return_cmd;
		end
	end

	// Stepping decision for the current state
	always_comb begin
		next_step = 1'b0;
		next_ccw  = 1'b0;
		case (state)
			st_pulse: begin
				next_step = pulse_edge && !halt_cmd;
				next_ccw  = pulse_ccw;
			end
			st_jog: begin
				next_step = (tick == 16'h0000);
				next_ccw  = reverse_jog_cmd;
			end
			st_home: begin
				next_step = (tick == 16'h0000) && (position != home_position);
				next_ccw  = position > home_position;
			end
			default: begin
				next_step = 1'b0;
				next_ccw  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tick <= 16'h0000;
		end else if (state == st_jog || state == st_home) begin
			tick <= (tick == 16'h0000) ? `JOG_PERIOD : tick - 16'h0001;
		end else begin
			tick <= 16'h0000;
		end
	end

	// Preparation delay after reset before step pulses are taken
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prep_count <= 16'h0000;
		end else if (state == st_prep && prep_count != 16'hFFFF) begin
			prep_count <= prep_count + 16'h0001;
		end
	end

	// A fault event wins over a simultaneous clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fault_latched <= 1'b0;
		end else if (fault_detect_in) begin
			fault_latched <= 1'b1;
		end else if (fault_clear_cmd) begin
			fault_latched <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= st_prep;
		end else begin
			case (state)
				st_prep: begin
					if (prep_count >= 16'(PREP_CYCLES - 1)) state <= st_idle;
				end
				st_idle, st_pulse: begin
					if (fault_latched) state <= st_fault;
					else if (free_cmd || !power_ok) state <= st_free;
					else if (halt_cmd) state <= st_idle;
					else if (home_return_cmd && !prev_home_cmd) state <= st_home;
					else if (forward_jog_cmd ^ reverse_jog_cmd) state <= st_jog;
					else state <= st_pulse;
				end
				st_jog: begin
					if (fault_latched) state <= st_fault;
					else if (free_cmd || !power_ok) state <= st_free;
					else if (halt_cmd || !(forward_jog_cmd ^ reverse_jog_cmd)) state <= st_idle;
				end
				st_home: begin
					if (fault_latched) state <= st_fault;
					else if (free_cmd || !power_ok) state <= st_free;
					else if (halt_cmd || position == home_position) state <= st_idle;
				end
				st_fault: begin
					if (!fault_latched) state <= st_idle;
				end
				st_free: begin
					if (fault_latched) state <= st_fault;
					else if (!free_cmd && power_ok) state <= st_idle;
				end
				default: state <= st_idle;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			position <= '0;
		end else if (next_step) begin
			position <= next_ccw ? position - 32'sd1 : position + 32'sd1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			home_position <= '0;
		end else if (home_preset_sw) begin
			home_position <= position;
		end
	end

	// Home done stays set until the shaft moves off home
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			home_done <= 1'b0;
		end else if (home_preset_sw) begin
			home_done <= 1'b1;
		end else if (state == st_home && position == home_position) begin
			home_done <= 1'b1;
		end else if (next_step) begin
			home_done <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pos_done <= 1'b0;
		end else if (next_step || state == st_jog || state == st_home) begin
			pos_done <= 1'b0;
		end else if (state == st_idle || state == st_pulse) begin
			pos_done <= 1'b1;
		end else begin
			pos_done <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			step_input_accepting_out <= 1'b0;
		end else begin
			step_input_accepting_out <= (state == st_pulse);
		end
	end

	// Unregistered so the motion output rises in the same cycle as the step it covers
	assign moving = (state == st_jog) || (state == st_home) || next_step;

	assign status_vec = {
		!fault_latched,
		moving,
		(state == st_idle || state == st_pulse) && !fault_latched,
		step_input_accepting_out,
		pos_done,
		home_done
	};

	// Per-output function selection through the assignment map
	genvar go;
	generate
		for (go = 0; go < N_OUT; go++) begin : g_out_map
			logic [3:0] code;
			assign code = OUT_MAP[go*4 +: 4];
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					gp_out[go] <= 1'b0;
				end else begin
					gp_out[go] <= (code < 4'h6) ? status_vec[code[2:0]] : 1'b0;
				end
			end
		end
	endgenerate

	// Drive enable needs both cutoff pins on and the state machine outside st_free and st_fault
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			drive_enable_out   <= 1'b0;
			cutoff_monitor_out <= 1'b0;
			step_out           <= 1'b0;
			step_ccw_out       <= 1'b0;
		end else begin
			drive_enable_out   <= power_ok && state != st_free && state != st_fault;
			cutoff_monitor_out <= !safety_cutoff_one_in && !safety_cutoff_two_in;
			step_out           <= next_step;
			step_ccw_out       <= next_ccw;
		end
	end

	quad_echo #(
		.PENDING_W (8)
	) u_quad (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.step_event (next_step),
		.step_ccw   (next_ccw),
		.phase_a    (quad_phase_a_out),
		.phase_b    (quad_phase_b_out)
	);
endmodule

// file: stepper_io_props.sv
// Port assertions for the stepper driver discrete I/O control block
`timescale 1ns/1ps
module stepper_io_props #(
	parameter int PREP_CYCLES = 10,
	parameter int N_IN        = 6,
	parameter int N_OUT       = 6
) (
	input wire logic             clk_sys,
	input wire logic             reset,
	input wire logic             one_pulse_mode_sw,
	input wire logic             clockwise_step_in,
	input wire logic             counter_clockwise_step_in,
	input wire logic [N_IN-1:0]  gp_in,
	input wire logic             safety_cutoff_one_in,
	input wire logic             safety_cutoff_two_in,
	input wire logic             fault_detect_in,
	input wire logic [N_OUT-1:0] gp_out,
	input wire logic             drive_enable_out,
	input wire logic             step_out,
	input wire logic             step_ccw_out,
	input wire logic             cutoff_monitor_out,
	input wire logic             quad_phase_a_out,
	input wire logic             quad_phase_b_out
);
	int unsigned up;
	// Only two-pulse traffic with no command active is judged step by step
	wire logic calm = gp_in == '0 && !fault_detect_in && !one_pulse_mode_sw && gp_out[2];
	always_ff @(posedge clk_sys) begin
		if (reset)
			up <= 0;
		else if (up < PREP_CYCLES)
			up <= up + 1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_monitor;
		!$past(reset) |-> cutoff_monitor_out ==
			(!$past(safety_cutoff_one_in) && !$past(safety_cutoff_two_in));
	endproperty
	a_monitor: assert property (p_monitor) else $error("cutoff monitor wrong");
	property p_cutoff;
		(!safety_cutoff_one_in || !safety_cutoff_two_in) [*2] |=> !drive_enable_out;
	endproperty
	a_cutoff: assert property (p_cutoff) else $error("drive left on");
	property p_cw;
		calm && $rose(clockwise_step_in) && !counter_clockwise_step_in
			|-> ##[1:3] step_out && !step_ccw_out;
	endproperty
	a_cw: assert property (p_cw) else $error("cw step missing");
	property p_ccw;
		calm && $rose(counter_clockwise_step_in) && !clockwise_step_in
			|-> ##[1:3] step_out && step_ccw_out;
	endproperty
	a_ccw: assert property (p_ccw) else $error("ccw step missing");
	property p_prep;
		gp_out[2] |-> up >= PREP_CYCLES;
	endproperty
	a_prep: assert property (p_prep) else $error("accepting too early");
	property p_motion;
		step_out |-> gp_out[4];
	endproperty
	a_motion: assert property (p_motion) else $error("motion low in step");
	property p_fault;
		fault_detect_in |-> ##[1:2] !gp_out[5];
	endproperty
	a_fault: assert property (p_fault) else $error("fault not shown");
	property p_quad;
		$changed(quad_phase_a_out) |-> $stable(quad_phase_b_out);
	endproperty
	a_quad: assert property (p_quad) else $error("both phases moved");
endmodule
bind stepper_driver_io_control stepper_io_props #(
	.PREP_CYCLES(PREP_CYCLES), .N_IN(N_IN), .N_OUT(N_OUT)
) i_stepper_io_props (.clk_sys, .reset, .one_pulse_mode_sw, .clockwise_step_in,
	.counter_clockwise_step_in, .gp_in, .safety_cutoff_one_in, .safety_cutoff_two_in,
	.fault_detect_in, .gp_out, .drive_enable_out, .step_out, .step_ccw_out,
	.cutoff_monitor_out, .quad_phase_a_out, .quad_phase_b_out);

// file: host_pulse_model.sv
// Host controller model issuing step pulses
`timescale 1ns/1ps
module host_pulse_model (
	input  wire logic clk_sys,
	input  wire logic one_pulse_mode_sw,
	input  wire logic req,
	input  wire logic sel_cw,
	input  wire logic sel_ccw,
	input  wire logic dir_level,
	output logic      clockwise_step_in,
	output logic      counter_clockwise_step_in
);
	logic [2:0] ph;
	logic       go;
	initial begin
		ph = 0;
		clockwise_step_in = 0;
		counter_clockwise_step_in = 0;
	end
	// Two high then at least three low cycles, so pulses never merge
	always @(posedge clk_sys) begin
		go = req;
		#1;
		if (ph != 0)
			ph = ph - 1;
		else if (go)
			ph = 4;
		clockwise_step_in = ph > 2 && (one_pulse_mode_sw || sel_cw);
		counter_clockwise_step_in = one_pulse_mode_sw ? dir_level : ph > 2 && sel_ccw;
	end
endmodule

// file: testbench.sv
// Self-checking bench for the stepper driver I/O control block
`timescale 1ns/1ps
module testbench;
	logic       clk_sys, reset, one_pulse_mode_sw, req, sel_cw, sel_ccw, dir_level;
	logic       clockwise_step_in, counter_clockwise_step_in, home_preset_sw, fault_detect_in;
	logic       safety_cutoff_one_in, safety_cutoff_two_in, drive_enable_out, step_out;
	logic       step_ccw_out, cutoff_monitor_out, quad_phase_a_out, quad_phase_b_out;
	logic [5:0] gp_in, gp_out;
	int         err_count = 0, num_checks = 0, cyc = 0, ncw = 0, nccw = 0;
	stepper_driver_io_control #(.PREP_CYCLES(10)) i_stepper_driver_io_control (.clk_sys,
		.reset, .one_pulse_mode_sw, .clockwise_step_in, .counter_clockwise_step_in, .gp_in,
		.safety_cutoff_one_in, .safety_cutoff_two_in, .home_preset_sw, .fault_detect_in,
		.gp_out, .drive_enable_out, .step_out, .step_ccw_out, .cutoff_monitor_out,
		.quad_phase_a_out, .quad_phase_b_out);
	host_pulse_model i_host_pulse_model (.clk_sys, .one_pulse_mode_sw, .req, .sel_cw,
		.sel_ccw, .dir_level, .clockwise_step_in, .counter_clockwise_step_in);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task end_sim;
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic wait_out(input int k);
		int n;
		n = 0;
		while (gp_out[k] !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
	endtask
	// One host pulse; q also judges the first quadrature move
	task automatic pulse(input logic c, cc, d, q, input int ecw, eccw);
		logic a0, b0;
		int   n;
		ncw = 0;
		nccw = 0;
		a0 = quad_phase_a_out;
		b0 = quad_phase_b_out;
		sel_cw = c;
		sel_ccw = cc;
		dir_level = d;
		req = 1;
		tick(1);
		req = 0;
		for (n = 0; q && n < 60 && {quad_phase_a_out, quad_phase_b_out} === {a0, b0}; n++)
			tick(1);
		if (q)
			check({quad_phase_a_out, quad_phase_b_out}, eccw ? {b0, !a0} : {!b0, a0});
		tick(12);
		check(ncw, ecw);
		check(nccw, eccw);
	endtask
	task t_steps;
		pulse(1, 0, 0, 0, 0, 0);
		wait_out(2);
		check({gp_out[5], gp_out[3], gp_out[1], drive_enable_out}, 4'hF);
		pulse(1, 0, 0, 1, 1, 0);
		pulse(0, 1, 0, 1, 0, 1);
		pulse(1, 1, 0, 0, 0, 0);
		one_pulse_mode_sw = 1;
		pulse(0, 0, 0, 0, 1, 0);
		pulse(0, 0, 1, 0, 0, 1);
		one_pulse_mode_sw = 0;
	endtask
	task t_refuse;
		gp_in = 6'h04;
		pulse(1, 0, 0, 0, 0, 0);
		gp_in = 6'h00;
		fault_detect_in = 1;
		tick(1);
		fault_detect_in = 0;
		tick(2);
		check({gp_out[5], gp_out[3]}, 2'h0);
		pulse(1, 0, 0, 0, 0, 0);
		gp_in = 6'h08;
		tick(1);
		gp_in = 6'h00;
		wait_out(2);
		check({gp_out[5], gp_out[3]}, 2'h3);
	endtask
	task t_cutoff;
		safety_cutoff_one_in = 0;
		tick(3);
		check({drive_enable_out, cutoff_monitor_out}, 2'h0);
		safety_cutoff_two_in = 0;
		tick(3);
		check({drive_enable_out, cutoff_monitor_out}, 2'h1);
		safety_cutoff_one_in = 1;
		safety_cutoff_two_in = 1;
		wait_out(2);
		check({drive_enable_out, cutoff_monitor_out}, 2'h2);
		gp_in = 6'h02;
		tick(3);
		check(drive_enable_out, 1'b0);
		gp_in = 6'h00;
		wait_out(2);
		check(drive_enable_out, 1'b1);
	endtask
	task t_jog_home;
		ncw = 0;
		gp_in = 6'h10;
		tick(4100);
		check(gp_out[4], 1'b1);
		gp_in = 6'h20;
		check(ncw != 0, 1);
		nccw = 0;
		tick(4100);
		gp_in = 6'h00;
		check(nccw != 0, 1);
		wait_out(2);
		home_preset_sw = 1;
		tick(1);
		home_preset_sw = 0;
		tick(3);
		check(gp_out[0], 1'b1);
		pulse(1, 0, 0, 0, 1, 0);
		pulse(1, 0, 0, 0, 1, 0);
		ncw = 0;
		nccw = 0;
		gp_in = 6'h01;
		tick(1);
		gp_in = 6'h00;
		tick(8200);
		check({ncw[3:0], nccw[3:0]}, 8'h02);
		check({gp_out[0], gp_out[1]}, 2'h3);
	endtask
	always @(posedge clk_sys) begin
		if (step_out === 1'b1 && step_ccw_out === 1'b1)
			nccw++;
		else if (step_out === 1'b1)
			ncw++;
		cyc++;
		// Longest path is jog plus home, well under this ceiling
		if (cyc == 30000) begin
			err_count++;
			$display("[ERR] %0t run did not finish", $time);
			end_sim;
		end
	end
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		reset = 1;
		{one_pulse_mode_sw, req, sel_cw, sel_ccw, dir_level} = 5'h00;
		{home_preset_sw, fault_detect_in, gp_in} = 8'h00;
		{safety_cutoff_one_in, safety_cutoff_two_in} = 2'h3;
		tick(4);
		reset = 0;
		check(gp_out[2], 1'b0);
		t_steps;
		t_refuse;
		t_cutoff;
		t_jog_home;
		end_sim;
	end
endmodule
